// ### core/dsb_map.vh
// constants for the burst-of-four ddr sram port model
// assumes one aclk edge per half k cycle; offsets are axi4-lite byte addresses
`ifndef DSB_MAP_VH
`define DSB_MAP_VH

`define DSB_ADDR_W 8
`define DSB_DATA_W 18
`define DSB_LANE_LO_MSB 8
`define DSB_BURST_LEN 3'd4
// half-steps from the command edge to the first beat, and to the last write beat
`define DSB_RD_FIRST_STEP 3'd3
`define DSB_WR_FIRST_STEP 3'd2
`define DSB_WR_LAST_STEP 3'd5
// register map
`define DSB_REG_CTRL 4'h0
`define DSB_REG_STATUS 4'h4
`define DSB_CTRL_RESET 32'h00000001
`define DSB_CTRL_EN_BIT 0
`define DSB_ST_RD_BUSY 0
`define DSB_ST_WR_BUSY 1
`define DSB_ST_SINGLE_CLK 2
`define DSB_ST_PENDING 3
`define DSB_RESP_OKAY 2'h0
`define DSB_RESP_SLVERR 2'h2

`endif

// ### core/dsb_axil_regs.v
// axi4-lite slave holding the control and status registers
// assumes one write and one read outstanding at most, aclk domain only
`include "dsb_map.vh"

module dsb_axil_regs (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write channels
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read channels
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // block side
    output wire ctrl_en,
    input wire [3:0] status
);
    reg aw_full_q;
    reg w_full_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg [31:0] ctrl_q;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign ctrl_en = ctrl_q[`DSB_CTRL_EN_BIT];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            ctrl_q <= `DSB_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DSB_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `DSB_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_full_q && w_full_q) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // status is read-only; writing it is answered okay and ignored
                if (awaddr_q == `DSB_REG_CTRL) begin
                    s_axi_bresp <= `DSB_RESP_OKAY;
                    if (wstrb_q[0]) begin
                        ctrl_q[7:0] <= wdata_q[7:0];
                    end
                end else if (awaddr_q == `DSB_REG_STATUS) begin
                    s_axi_bresp <= `DSB_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `DSB_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (s_axi_araddr == `DSB_REG_CTRL) begin
                    s_axi_rdata <= ctrl_q;
                    s_axi_rresp <= `DSB_RESP_OKAY;
                end else if (s_axi_araddr == `DSB_REG_STATUS) begin
                    s_axi_rdata <= {28'h0000000, status};
                    s_axi_rresp <= `DSB_RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `DSB_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // dsb_axil_regs

// ### core/dsb_sram_port.v
// burst-of-four common-i/o ddr sram: command decode, read/write bursts, write buffer, array
// assumes aclk ticks once per half k cycle and k_rise marks the true k edges
// Functional notes
// RULE1: the controller issues a read at the start of cycle t and a write at the start of t+1.
// RULE2: a load on a true k edge with read_not_write high starts a read burst.
// RULE3: a load on a true k edge with read_not_write low starts a write burst.
// RULE4: a k edge with load_strobe_n high is an idle_command and leaves the data pins undriven.
// RULE5: read beats go out three, four, five and six half-steps after the command, inverted edge first.
// RULE6: the controller presents the four write beats on alternating true and inverted k edges.
// RULE7: while the clock is stopped nothing changes and the data pins hold their previous state.
// RULE8: each write beat carries its own lane masks, applied to that beat only.
// RULE9: lane_mask_low_n low writes bits 0 to 8, lane_mask_high_n low writes bits 9 to 17.
// RULE10: a beat with both lane masks high is aborted and its data ignored.
// RULE11: the controller holds read_not_write low at the edge on which a write is commanded.
// RULE12: burst addresses count linearly from the loaded address, wrapping in the low two bits.
// RULE13: write data waits in a buffer until a later write commits it; reads see the buffer.
// RULE14: the controller pulls load_strobe_n low whenever it presents a new address.
// RULE15: with both output clocks tied high from reset, read beats are timed from k alone.
// RULE16: the controller releases the data bus while read beats are returned.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`include "dsb_map.vh"

module dsb_sram_port (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // clocks seen as levels
    input wire k_rise,
    input wire k_stopped,
    input wire c_true,
    input wire c_inv,
    // command pins
    input wire load_strobe_n,
    input wire read_not_write,
    input wire [`DSB_ADDR_W-1:0] addr,
    input wire lane_mask_low_n,
    input wire lane_mask_high_n,
    // common data bus
    input wire [`DSB_DATA_W-1:0] dq_i,
    output reg [`DSB_DATA_W-1:0] dq_o,
    output reg dq_oe
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    reg [`DSB_DATA_W-1:0] mem [0:(1<<`DSB_ADDR_W)-1];
    reg [`DSB_DATA_W-1:0] pdata [0:3];
    reg [1:0] pmask [0:3];
    reg [`DSB_ADDR_W-1:0] pwaddr [0:3];
    reg [3:0] pvalid_q;
    reg [1:0] rd_state_q;
    reg [2:0] rd_step_q;
    reg [2:0] rd_idx_q;
    reg [`DSB_ADDR_W-1:0] rd_base_q;
    reg [1:0] wr_state_q;
    reg [2:0] wr_step_q;
    reg [`DSB_ADDR_W-1:0] wr_base_q;
    reg single_q;
    reg strap_done_q;
    reg c_true_q;
    reg c_inv_q;
    reg [`DSB_DATA_W-1:0] rd_word;
    wire ctrl_en;
    wire load;
    wire beat_due;
    wire [1:0] wr_beat;
    wire [`DSB_ADDR_W-1:0] rd_addr;
    integer j;

    function [`DSB_ADDR_W-1:0] burst_addr;
        input [`DSB_ADDR_W-1:0] base;
        input [1:0] idx;
        begin
            burst_addr = {base[`DSB_ADDR_W-1:2], base[1:0] + idx}; // RULE12
        end
    endfunction

    function [`DSB_DATA_W-1:0] merge;
        input [`DSB_DATA_W-1:0] old;
        input [`DSB_DATA_W-1:0] upd;
        input [1:0] lanes;
        reg [`DSB_DATA_W-1:0] m;
        begin
            m = {{(`DSB_DATA_W-`DSB_LANE_LO_MSB-1){lanes[1]}}, {(`DSB_LANE_LO_MSB+1){lanes[0]}}}; // RULE9
            merge = (old & ~m) | (upd & m);
        end
    endfunction

    dsb_axil_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .ctrl_en(ctrl_en),
        .status({|pvalid_q, single_q, wr_state_q[1], rd_state_q[1]})
    );

    // idle_command edges fall through here and never touch dq_oe
    assign load = k_rise && !load_strobe_n && ctrl_en && !k_stopped; // RULE4
    assign rd_addr = burst_addr(rd_base_q, rd_idx_q[1:0]);
    assign wr_beat = wr_step_q[1:0] - 2'd2;
    // with output clocks running, even beats leave on the inverted one and odd beats on the true one; in single mode k alone times them
    assign beat_due = rd_state_q[1] && rd_idx_q < `DSB_BURST_LEN
        && rd_step_q >= `DSB_RD_FIRST_STEP + rd_idx_q
        && (single_q || (rd_idx_q[0] ? (c_true && !c_true_q) : (c_inv && !c_inv_q))); // RULE5 RULE15

    // newest buffered data wins over the array so reads stay coherent
    always @* begin
        rd_word = mem[rd_addr];
        for (j = 0; j < 4; j = j + 1) begin
            if (pvalid_q[j] && pwaddr[j] == rd_addr) begin
                rd_word = merge(rd_word, pdata[j], pmask[j]); // RULE13
            end
        end
    end

    // strap is caught on the first edge after release, not under reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_done_q <= 1'b0;
            single_q <= 1'b0;
            c_true_q <= 1'b0;
            c_inv_q <= 1'b0;
        end else begin
            c_true_q <= c_true;
            c_inv_q <= c_inv;
            if (!strap_done_q) begin
                strap_done_q <= 1'b1;
                single_q <= c_true && c_inv; // RULE15
            end
        end
    end

    // read engine; a new read restarts the burst, the controller keeps them spaced
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= ST_IDLE;
            rd_step_q <= 3'd0;
            rd_idx_q <= 3'd0;
            rd_base_q <= {`DSB_ADDR_W{1'b0}};
            dq_o <= {`DSB_DATA_W{1'b0}};
            dq_oe <= 1'b0;
        end else if (!k_stopped) begin // RULE7
            if (load && read_not_write) begin // RULE2
                rd_state_q <= ST_RUN;
                rd_step_q <= 3'd1;
                rd_idx_q <= 3'd0;
                rd_base_q <= addr;
            end else begin
                case (rd_state_q)
                    ST_RUN: begin
                        if (rd_step_q != 3'd7) begin
                            rd_step_q <= rd_step_q + 3'd1;
                        end
                        if (beat_due) begin
                            dq_o <= rd_word; // RULE5
                            dq_oe <= 1'b1;
                            rd_idx_q <= rd_idx_q + 3'd1;
                        end else if (rd_idx_q == `DSB_BURST_LEN) begin
                            dq_oe <= 1'b0;
                            rd_state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        dq_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // write engine; each captured beat evicts the older beat in its slot into the array
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= ST_IDLE;
            wr_step_q <= 3'd0;
            wr_base_q <= {`DSB_ADDR_W{1'b0}};
            pvalid_q <= 4'h0;
        end else if (!k_stopped) begin // RULE7
            if (load && !read_not_write) begin // RULE3
                wr_state_q <= ST_RUN;
                wr_step_q <= 3'd1;
                wr_base_q <= addr;
            end else begin
                case (wr_state_q)
                    ST_RUN: begin
                        wr_step_q <= wr_step_q + 3'd1;
                        if (wr_step_q == `DSB_WR_LAST_STEP) begin
                            wr_state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        wr_step_q <= 3'd0;
                    end
                endcase
            end
            if (wr_state_q[1] && wr_step_q >= `DSB_WR_FIRST_STEP) begin
                if (pvalid_q[wr_beat]) begin
                    mem[pwaddr[wr_beat]] <= merge(mem[pwaddr[wr_beat]], pdata[wr_beat], pmask[wr_beat]); // RULE13
                end
                pdata[wr_beat] <= dq_i;
                pmask[wr_beat] <= {!lane_mask_high_n, !lane_mask_low_n}; // RULE8 RULE10
                pwaddr[wr_beat] <= burst_addr(wr_base_q, wr_beat); // RULE12
                pvalid_q[wr_beat] <= 1'b1;
            end
        end
    end
endmodule // dsb_sram_port

// ### tb/dsb_sram_port_props.sv
// checker for the sram port: read window, idle and stop behaviour, read handshake
// assumes output clocks tied high or in step with k, and control writes with aw and w taken on one edge
`include "dsb_map.vh"
module dsb_sram_port_props (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // memory link
    input wire k_rise,
    input wire k_stopped,
    input wire load_strobe_n,
    input wire read_not_write,
    input wire [`DSB_DATA_W-1:0] dq_o,
    input wire dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic en_q;
    logic [6:0] rd_sr;
    wire go = k_rise && !load_strobe_n && !k_stopped;
    wire rd_cmd = go && read_not_write && en_q;
    wire wr_cmd = go && !read_not_write && en_q;
    // mirror of the enable bit, so refused commands are not expected to run
    always @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 1'b1;
            rd_sr <= 7'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `DSB_REG_CTRL)
                en_q <= s_axi_wdata[`DSB_CTRL_EN_BIT];
            rd_sr <= {rd_sr[5:0], rd_cmd};
        end
    end
    property p_oe_window;
        dq_oe == (|rd_sr[6:3]);
    endproperty
    a_oe_window: assert property (p_oe_window) else $error("read drive outside its window");
    property p_rd_beats;
        rd_cmd |-> ##4 dq_oe [*4] ##1 !dq_oe;
    endproperty
    a_rd_beats: assert property (p_rd_beats) else $error("read burst not four beats");
    property p_wr_quiet;
        wr_cmd && rd_sr == 7'h00 |=> !dq_oe [*3];
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("write drove the bus");
    property p_idle;
        k_rise && load_strobe_n && rd_sr == 7'h00 |=> !dq_oe [*3];
    endproperty
    a_idle: assert property (p_idle) else $error("idle edge drove the bus");
    property p_off;
        go && !en_q && rd_sr == 7'h00 |=> !dq_oe [*3];
    endproperty
    a_off: assert property (p_off) else $error("disabled command ran");
    property p_stop;
        k_stopped |=> $stable(dq_o) && $stable(dq_oe);
    endproperty
    a_stop: assert property (p_stop) else $error("data pins moved while stopped");
    property p_ar_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read address taken while answering");
    c_rd: cover property (rd_cmd);
    c_wr: cover property (wr_cmd);
    c_stop: cover property (k_stopped);
endmodule // dsb_sram_port_props

bind dsb_sram_port dsb_sram_port_props u_dsb_sram_port_props (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .k_rise,
    .k_stopped, .load_strobe_n, .read_not_write, .dq_o, .dq_oe
);

// ### tb/dsb_ctl_model.sv
// memory controller model: k phase, commands, write beats, read capture
// assumes single-clock timing with one aclk edge per half k cycle
`include "dsb_map.vh"
module dsb_ctl_model (
    // clock
    input wire logic aclk,
    // command pins
    output logic k_rise,
    output logic load_strobe_n,
    output logic read_not_write,
    output logic [`DSB_ADDR_W-1:0] addr,
    output logic lane_mask_low_n,
    output logic lane_mask_high_n,
    // data
    output logic [`DSB_DATA_W-1:0] dq_i,
    input wire logic [`DSB_DATA_W-1:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial begin
        k_rise = 1'b0;
        load_strobe_n = 1'b1;
        read_not_write = 1'b1;
        addr = '0;
        {lane_mask_high_n, lane_mask_low_n} = 2'b11;
        dq_i = '0;
    end
    // released data lines wander so a stale word is never mistaken for data
    always @(posedge aclk) begin
        k_rise <= ~k_rise;
        if (!busy)
            dq_i <= ~dq_i;
    end
    task automatic cmd(input logic rd, input logic [`DSB_ADDR_W-1:0] a);
        @(posedge aclk);
        if (k_rise)
            @(posedge aclk);
        load_strobe_n <= 1'b0;
        read_not_write <= rd;
        addr <= a;
        @(posedge aclk);
        load_strobe_n <= 1'b1;
    endtask
    task automatic wr(input logic [`DSB_ADDR_W-1:0] a, input logic [3:0][`DSB_DATA_W-1:0] d, input logic [7:0] m);
        busy = 1'b1;
        cmd(1'b0, a);
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            dq_i <= d[i];
            {lane_mask_high_n, lane_mask_low_n} <= m[2*i +: 2];
            @(posedge aclk);
        end
        {lane_mask_high_n, lane_mask_low_n} <= 2'b11;
        busy = 1'b0;
    endtask
    task automatic rd(input logic [`DSB_ADDR_W-1:0] a, output logic [3:0][`DSB_DATA_W-1:0] q);
        cmd(1'b1, a);
        repeat (3) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            q[i] = dq_o;
        end
    endtask
endmodule // dsb_ctl_model

// ### tb/dsb_sram_port_tb.sv
// self-checking bench: register bus tasks plus controller model bursts
// assumes the model in dsb_ctl_model and the bound checker
`include "dsb_map.vh"
module dsb_sram_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int L = `DSB_LANE_LO_MSB;
    logic aclk, aresetn, k_rise, k_stopped, load_strobe_n, read_not_write, lane_mask_low_n, lane_mask_high_n, dq_oe;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [`DSB_ADDR_W-1:0] addr;
    logic [`DSB_DATA_W-1:0] dq_i, dq_o;
    logic [3:0][`DSB_DATA_W-1:0] d, e, q, x;
    int bad_count, total_checks, cyc;
    // output clocks either tied high (single mode) or running in step with k
    logic dual;
    wire c_true = !dual || k_rise;
    wire c_inv = !dual || !k_rise;
    dsb_sram_port u_dsb_sram_port (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .k_rise, .k_stopped, .c_true, .c_inv, .load_strobe_n, .read_not_write, .addr,
        .lane_mask_low_n, .lane_mask_high_n, .dq_i, .dq_o, .dq_oe
    );
    dsb_ctl_model u_dsb_ctl_model (
        .aclk, .k_rise, .load_strobe_n, .read_not_write, .addr, .lane_mask_low_n, .lane_mask_high_n,
        .dq_i, .dq_o
    );
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [`DSB_DATA_W-1:0] mrg(input logic [`DSB_DATA_W-1:0] o, n, input logic [1:0] m);
        mrg = o;
        if (!m[0])
            mrg[L:0] = n[L:0];
        if (!m[1])
            mrg[`DSB_DATA_W-1:L+1] = n[`DSB_DATA_W-1:L+1];
    endfunction
    task automatic axw(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] rsp);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        dat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // a hang ends the run through the same report
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        {aresetn, k_stopped, dual, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {bad_count, total_checks, cyc} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(4'h0, v, r);
        chk(v, `DSB_CTRL_RESET);
        axr(4'h4, v, r);
        chk(v[3:0], 4'b0100);
        axr(4'h8, v, r);
        chk({r, v}, {`DSB_RESP_SLVERR, 32'h0});
        d = {18'h2A5A5, 18'h15A5A, 18'h3C3C3, 18'h0F0F0};
        u_dsb_ctl_model.wr(8'h12, d, 8'h00);
        axr(4'h4, v, r);
        chk(v[3:0], 4'b1100);
        u_dsb_ctl_model.rd(8'h10, q);
        chk(q, {d[1], d[0], d[3], d[2]});
        // beat masks: low lane, high lane, abort, both
        e = {18'h11111, 18'h22222, 18'h33333, 18'h04444};
        u_dsb_ctl_model.wr(8'h10, e, 8'h36);
        for (int i = 0; i < 4; i++)
            x[i] = mrg(q[i], e[i], 2'(8'h36 >> (2 * i)));
        u_dsb_ctl_model.rd(8'h10, q);
        chk(q, x);
        u_dsb_ctl_model.wr(8'h40, d, 8'h00);
        u_dsb_ctl_model.rd(8'h10, q);
        chk(q, x);
        k_stopped <= 1'b1;
        repeat (6) @(posedge aclk);
        k_stopped <= 1'b0;
        axw(4'h0, 32'h0, r);
        chk(r, `DSB_RESP_OKAY);
        axr(4'h0, v, r);
        chk(v, 32'h0);
        u_dsb_ctl_model.rd(8'h10, q);
        chk(q, {4{x[3]}});
        axw(4'h8, 32'h1, r);
        chk(r, `DSB_RESP_SLVERR);
        axw(4'h4, 32'h0, r);
        chk(r, `DSB_RESP_OKAY);
        axw(4'h0, 32'h1, r);
        u_dsb_ctl_model.rd(8'h40, q);
        chk(q, d);
        // second reset in mid-run, output clocks now running: buffer is dropped
        dual <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(4'h4, v, r);
        chk(v[3:0], 4'b0000);
        u_dsb_ctl_model.wr(8'h23, e, 8'h00);
        u_dsb_ctl_model.rd(8'h20, q);
        chk(q, {e[0], e[3], e[2], e[1]});
        repeat (10) @(posedge aclk);
        test_done;
    end
endmodule // dsb_sram_port_tb
